/* core/uart_host_pkg.sv */
// Operation
// [R1] Eight data lines, three address lines
// [R2] Bus cycles need no oscillator running
// [R3] Chip select qualifies strobes or direction
// [R4] Mode input picks strobe or direction style
// [R5] Reset pulse over 40 ns clears state
// [R6] Zero divisor reads back device, revision codes
// [R7] Legacy DMA bit has no effect
// [R8] Transmit interrupt level and polarity by mode
// [R9] Receive interrupt level and polarity by mode
// [R10] Oscillator clocks generator, buffered copy out
// [R11] Modem control bit 7 picks prescale 1/4
// [R12] Sixteen-bit divisor yields 16x sample tick
// [R13] Sample tick times transmit and receive
// [R14] Divisor resets to one
// [R15] Software computes divisor from clock, rate
// [R16] Divisor bytes apply at next reload
package uart_host_pkg;

	// ==========================================
	// Device register map
	localparam logic [2:0] A_DIV_LO = 3'h0;
	localparam logic [2:0] A_DIV_HI = 3'h1;
	localparam logic [2:0] A_FIFO_CTRL = 3'h2;
	localparam logic [2:0] A_MODEM_CTRL = 3'h4;
	localparam logic [2:0] A_IRQ_STATE = 3'h5;
	localparam int FCR_FIFO_EN_BIT = 0;
	localparam int FCR_DMA_BIT = 3;
	localparam int MCR_PRESCALE_BIT = 7;
	localparam logic [7:0] DIV_LO_RST = 8'h01;
	localparam logic [7:0] DIV_HI_RST = 8'h00;
	localparam logic [7:0] FCR_RST = 8'h00;
	localparam logic [7:0] MCR_RST = 8'h00;
	localparam logic [1:0] PRESCALE_LAST = 2'h3;
	localparam logic [7:0] IDLE_BUS = 8'hFF;

	// ==========================================
	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int RESET_PULSE_NS = 40;
	localparam logic [3:0] RESET_PULSE_CYC =
		4'((RESET_PULSE_NS + CLK_PERIOD_NS) / CLK_PERIOD_NS);
	localparam logic [3:0] BUS_HOLD_CYC = 4'h3;

	// ==========================================
	// Controller registers on APB
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_WDATA = 8'h04;
	localparam logic [7:0] REG_RDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_IRQ_STAT = 8'h10;
	localparam logic [7:0] REG_IRQ_MASK = 8'h14;
	localparam logic [7:0] REG_CTRL = 8'h18;
	localparam int CMD_WRITE_BIT = 8;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_DEV_BIT = 1;
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_RESET_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_IRQ_BIT = 1;

	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_SETUP = 3'b001,
		H_STROBE = 3'b010,
		H_RECOVER = 3'b011,
		H_RESET = 3'b100
	} host_state_e;

endpackage : uart_host_pkg

/* core/uart_bus_if.sv */
`timescale 1ns/1ps
interface uart_bus_if;
	logic cs_n;
	logic read_strobe_n;
	logic write_strobe_n;
	logic rw_n;
	logic strobe_mode;
	logic dev_reset_n;
	logic [2:0] addr;
	logic [7:0] host_data;
	logic host_oe;
	logic [7:0] dev_data;
	logic dev_oe;
	logic irq_pin;
	// Resolved data lines; undriven bus floats high
	wire [7:0] data = host_oe ? host_data :
		(dev_oe ? dev_data : uart_host_pkg::IDLE_BUS);

	modport host(
		output cs_n, read_strobe_n, write_strobe_n, rw_n,
		output strobe_mode, dev_reset_n, addr, host_data, host_oe,
		input data, irq_pin
	);
	modport device(
		input cs_n, read_strobe_n, write_strobe_n, rw_n,
		input strobe_mode, dev_reset_n, addr, data,
		output dev_data, dev_oe, irq_pin
	);
endinterface : uart_bus_if

/* core/uart_dev_end.sv */
`timescale 1ns/1ps
module uart_dev_end
	import uart_host_pkg::*;
#(
	// Arbitrary identification values
	parameter logic [7:0] DEVICE_CODE = 8'h5A,
	parameter logic [7:0] REVISION_CODE = 8'h3C
) (
	input wire logic CLK,
	input wire logic RESET_N,
	uart_bus_if.device BUS,
	input wire logic OSC_IN,
	input wire logic THR_EMPTY,
	input wire logic TX_BELOW_TRIG,
	input wire logic RX_BYTE_HELD,
	input wire logic RX_ABOVE_TRIG,
	output logic OSC_BUFFERED_OUT,
	output logic SAMPLE_TICK,
	output logic FIFO_ENABLE
);

	// ==========================================
	// Bus decode
	logic soft_rst;
	logic wr_act;
	logic rd_act;
	logic [15:0] divisor;
	logic tx_int;
	logic rx_int;
	logic [7:0] div_lo_ff;
	logic [7:0] div_hi_ff;
	logic [7:0] fcr_ff;
	logic [7:0] mcr_ff;

	assign soft_rst = ~BUS.dev_reset_n;
	// Strobe style: separate strobes; else rw_n
	assign wr_act = ~BUS.cs_n & (BUS.strobe_mode ?
		~BUS.write_strobe_n : ~BUS.rw_n); // [R3] [R4]
	assign rd_act = ~BUS.cs_n & (BUS.strobe_mode ?
		~BUS.read_strobe_n : BUS.rw_n); // [R3] [R4]
	assign divisor = {div_hi_ff, div_lo_ff}; // [R16]

	// Interrupt sources by FIFO mode
	assign tx_int = fcr_ff[FCR_FIFO_EN_BIT] ?
		TX_BELOW_TRIG : THR_EMPTY; // [R8]
	assign rx_int = fcr_ff[FCR_FIFO_EN_BIT] ?
		RX_ABOVE_TRIG : RX_BYTE_HELD; // [R9]

	// ==========================================
	// Register file
	logic wr_seen_ff;
	logic [7:0] rd_data_ff;
	logic rd_oe_ff;
	logic [7:0] nxt_div_lo;
	logic [7:0] nxt_div_hi;
	logic [7:0] nxt_fcr;
	logic [7:0] nxt_mcr;
	logic nxt_wr_seen;
	logic [7:0] nxt_rd_data;
	logic nxt_rd_oe;

	function automatic logic [7:0] read_reg(
		input logic [2:0] a,
		input logic [7:0] lo,
		input logic [7:0] hi,
		input logic [7:0] fifo_ctrl_reg,
		input logic [7:0] modem_ctrl_reg,
		input logic [1:0] irqs
	);
		logic zero_div;
		zero_div = (lo == 8'h00) && (hi == 8'h00);
		case (a)
			A_DIV_LO: read_reg = zero_div ? REVISION_CODE : lo; // [R6]
			A_DIV_HI: read_reg = zero_div ? DEVICE_CODE : hi; // [R6]
			A_FIFO_CTRL: read_reg = fifo_ctrl_reg;
			A_MODEM_CTRL: read_reg = modem_ctrl_reg;
			A_IRQ_STATE: read_reg = {6'h00, irqs};
			default: read_reg = 8'h00;
		endcase
	endfunction : read_reg

	// Bus side runs on CLK only, never on OSC_IN
	always_comb begin // [R2]
		nxt_div_lo = div_lo_ff;
		nxt_div_hi = div_hi_ff;
		nxt_fcr = fcr_ff;
		nxt_mcr = mcr_ff;
		nxt_wr_seen = wr_act;
		nxt_rd_oe = rd_act;
		nxt_rd_data = read_reg(BUS.addr, div_lo_ff, div_hi_ff,
			fcr_ff, mcr_ff, {rx_int, tx_int});
		// One commit per strobe, on its leading edge
		if (wr_act && !wr_seen_ff) begin // [R1]
			case (BUS.addr)
				A_DIV_LO: nxt_div_lo = BUS.data; // [R16]
				A_DIV_HI: nxt_div_hi = BUS.data; // [R16]
				A_FIFO_CTRL: nxt_fcr = BUS.data; // [R7]
				A_MODEM_CTRL: nxt_mcr = BUS.data;
				default: nxt_wr_seen = wr_act;
			endcase
		end
		if (soft_rst) begin // [R5]
			nxt_div_lo = DIV_LO_RST; // [R14]
			nxt_div_hi = DIV_HI_RST; // [R14]
			nxt_fcr = FCR_RST;
			nxt_mcr = MCR_RST;
			nxt_wr_seen = 1'b0;
			nxt_rd_oe = 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			div_lo_ff <= DIV_LO_RST; // [R14]
			div_hi_ff <= DIV_HI_RST; // [R14]
			fcr_ff <= FCR_RST;
			mcr_ff <= MCR_RST;
			wr_seen_ff <= 1'b0;
			rd_data_ff <= 8'h00;
			rd_oe_ff <= 1'b0;
		end else begin
			div_lo_ff <= nxt_div_lo;
			div_hi_ff <= nxt_div_hi;
			fcr_ff <= nxt_fcr;
			mcr_ff <= nxt_mcr;
			wr_seen_ff <= nxt_wr_seen;
			rd_data_ff <= nxt_rd_data;
			rd_oe_ff <= nxt_rd_oe;
		end
	end

	assign BUS.dev_data = rd_data_ff; // [R1]
	assign BUS.dev_oe = rd_oe_ff;

	// ==========================================
	// Prescaler and baud divider
	logic osc_ff;
	logic osc_buf_ff;
	logic [1:0] pre_cnt_ff;
	logic [15:0] div_cnt_ff;
	logic tick_ff;
	logic nxt_osc;
	logic [1:0] nxt_pre_cnt;
	logic [15:0] nxt_div_cnt;
	logic nxt_tick;
	logic osc_rise;
	logic pre_tick;

	always_comb begin
		nxt_osc = OSC_IN; // [R10]
		osc_rise = OSC_IN & ~osc_ff; // [R10]
		nxt_pre_cnt = 2'h0;
		pre_tick = osc_rise;
		if (mcr_ff[MCR_PRESCALE_BIT]) begin // [R11]
			nxt_pre_cnt = osc_rise ? pre_cnt_ff + 2'h1 : pre_cnt_ff;
			pre_tick = osc_rise && (pre_cnt_ff == PRESCALE_LAST);
		end
		nxt_div_cnt = div_cnt_ff;
		nxt_tick = 1'b0;
		// Zero divisor parks the generator
		if (pre_tick && divisor != 16'h0000) begin // [R12]
			if (div_cnt_ff <= 16'h0001) begin
				nxt_div_cnt = divisor; // [R16]
				nxt_tick = 1'b1; // [R13]
			end else begin
				nxt_div_cnt = div_cnt_ff - 16'h0001;
			end
		end
		if (soft_rst) begin // [R5]
			nxt_pre_cnt = 2'h0;
			nxt_div_cnt = 16'h0000;
			nxt_tick = 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			osc_ff <= 1'b0;
			osc_buf_ff <= 1'b0;
			pre_cnt_ff <= 2'h0;
			div_cnt_ff <= 16'h0000;
			tick_ff <= 1'b0;
		end else begin
			osc_ff <= nxt_osc;
			osc_buf_ff <= nxt_osc;
			pre_cnt_ff <= nxt_pre_cnt;
			div_cnt_ff <= nxt_div_cnt;
			tick_ff <= nxt_tick;
		end
	end

	// ==========================================
	// Interrupt pin and status outputs
	logic irq_ff;
	logic fifo_en_ff;
	logic nxt_irq;
	logic nxt_fifo_en;

	always_comb begin
		// Active high in strobe style, low otherwise
		nxt_irq = BUS.strobe_mode ? (tx_int | rx_int) :
			~(tx_int | rx_int); // [R8] [R9]
		nxt_fifo_en = fcr_ff[FCR_FIFO_EN_BIT];
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			irq_ff <= 1'b0;
			fifo_en_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_irq;
			fifo_en_ff <= nxt_fifo_en;
		end
	end

	assign BUS.irq_pin = irq_ff;
	assign OSC_BUFFERED_OUT = osc_buf_ff; // [R10]
	assign SAMPLE_TICK = tick_ff; // [R13]
	assign FIFO_ENABLE = fifo_en_ff;

endmodule : uart_dev_end

/* core/uart_host_end.sv */
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module uart_host_end
	import uart_host_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic IRQ,
	uart_bus_if.host BUS
);

	// ==========================================
	// APB slave
	logic [2:0] cmd_addr_ff;
	logic cmd_write_ff;
	logic [7:0] wdata_ff;
	logic [7:0] rdata_ff;
	logic mode_ff;
	logic [1:0] stat_ff;
	logic [1:0] mask_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic irq_ff;
	logic irq_prev_ff;
	host_state_e state_ff;
	logic [3:0] cnt_ff;
	logic wr_en;
	logic busy;
	logic dev_irq;
	logic [1:0] nxt_stat;
	logic [31:0] nxt_prdata;
	logic nxt_pslverr;
	logic nxt_pready;
	logic nxt_irq;

	assign wr_en = PSEL & PENABLE & PWRITE & pready_ff;
	assign busy = state_ff != H_IDLE;
	// Pin level to active flag, by bus style
	assign dev_irq = mode_ff ? BUS.irq_pin : ~BUS.irq_pin; // [R8] [R9]

	always_comb begin
		nxt_prdata = 32'h0000_0000;
		nxt_pslverr = 1'b0;
		case (PADDR)
			REG_CMD: nxt_prdata = {23'h0, cmd_write_ff, 5'h0, cmd_addr_ff};
			REG_WDATA: nxt_prdata = {24'h0, wdata_ff};
			REG_RDATA: nxt_prdata = {24'h0, rdata_ff};
			REG_STATUS: nxt_prdata = {30'h0, dev_irq, busy};
			REG_IRQ_STAT: nxt_prdata = {30'h0, stat_ff};
			REG_IRQ_MASK: nxt_prdata = {30'h0, mask_ff};
			REG_CTRL: nxt_prdata = {31'h0, mode_ff};
			default: nxt_pslverr = 1'b1;
		endcase
		// Set beats a same-cycle write-one clear
		nxt_stat = stat_ff;
		if (wr_en && PADDR == REG_IRQ_STAT) begin
			nxt_stat = stat_ff & ~PWDATA[1:0];
		end
		if (state_ff == H_RECOVER || (state_ff == H_RESET &&
			cnt_ff == 4'h1)) begin
			nxt_stat[IRQ_DONE_BIT] = 1'b1;
		end
		if (dev_irq && !irq_prev_ff) begin
			nxt_stat[IRQ_DEV_BIT] = 1'b1;
		end
		// Ready only in the first access cycle, no waits
		nxt_pready = PSEL & ~PENABLE;
		nxt_pslverr = nxt_pready & nxt_pslverr;
		nxt_irq = |(nxt_stat & mask_ff);
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			stat_ff <= 2'h0;
			irq_ff <= 1'b0;
			irq_prev_ff <= 1'b0;
		end else begin
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			stat_ff <= nxt_stat;
			irq_ff <= nxt_irq;
			irq_prev_ff <= dev_irq;
		end
	end

	assign PRDATA = prdata_ff;
	assign PREADY = pready_ff;
	assign PSLVERR = pslverr_ff;
	assign IRQ = irq_ff;

	// ==========================================
	// Parallel bus sequencer
	logic cs_n_ff;
	logic strobe_n_ff;
	logic hoe_ff;
	logic dev_rst_n_ff;
	host_state_e nxt_state;
	logic [3:0] nxt_cnt;
	logic nxt_cs_n;
	logic nxt_strobe_n;
	logic nxt_hoe;
	logic nxt_dev_rst_n;
	logic [2:0] nxt_cmd_addr;
	logic nxt_cmd_write;
	logic [7:0] nxt_wdata;
	logic [7:0] nxt_rdata;
	logic nxt_mode;
	logic [1:0] nxt_mask;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_cs_n = 1'b1;
		nxt_strobe_n = 1'b1;
		nxt_hoe = 1'b0;
		nxt_dev_rst_n = 1'b1;
		nxt_cmd_addr = cmd_addr_ff;
		nxt_cmd_write = cmd_write_ff;
		nxt_wdata = wdata_ff;
		nxt_rdata = rdata_ff;
		nxt_mode = mode_ff;
		nxt_mask = mask_ff;
		if (wr_en && PADDR == REG_WDATA && !busy) begin
			nxt_wdata = PWDATA[7:0];
		end
		if (wr_en && PADDR == REG_IRQ_MASK) begin
			nxt_mask = PWDATA[1:0];
		end
		if (wr_en && PADDR == REG_CTRL && !busy) begin
			nxt_mode = PWDATA[CTRL_MODE_BIT]; // [R4]
		end
		case (state_ff)
			H_IDLE: begin
				if (wr_en && PADDR == REG_CMD) begin
					nxt_cmd_addr = PWDATA[2:0]; // [R1]
					nxt_cmd_write = PWDATA[CMD_WRITE_BIT];
					nxt_hoe = PWDATA[CMD_WRITE_BIT];
					nxt_state = H_SETUP;
				end else if (wr_en && PADDR == REG_CTRL &&
					PWDATA[CTRL_RESET_BIT]) begin
					nxt_dev_rst_n = 1'b0; // [R5]
					nxt_cnt = RESET_PULSE_CYC;
					nxt_state = H_RESET;
				end
			end
			H_SETUP: begin
				nxt_hoe = cmd_write_ff;
				nxt_cs_n = 1'b0; // [R3]
				nxt_strobe_n = 1'b0;
				nxt_cnt = BUS_HOLD_CYC;
				nxt_state = H_STROBE;
			end
			H_STROBE: begin
				nxt_hoe = cmd_write_ff;
				nxt_cnt = cnt_ff - 4'h1;
				if (cnt_ff == 4'h1) begin
					if (!cmd_write_ff) begin
						nxt_rdata = BUS.data;
					end
					nxt_state = H_RECOVER;
				end else begin
					nxt_cs_n = 1'b0;
					nxt_strobe_n = 1'b0;
				end
			end
			H_RECOVER: nxt_state = H_IDLE;
			H_RESET: begin
				nxt_cnt = cnt_ff - 4'h1;
				if (cnt_ff == 4'h1) begin
					nxt_state = H_IDLE;
				end else begin
					nxt_dev_rst_n = 1'b0; // [R5]
				end
			end
			default: nxt_state = H_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_ff <= H_IDLE;
			cnt_ff <= 4'h0;
			cs_n_ff <= 1'b1;
			strobe_n_ff <= 1'b1;
			hoe_ff <= 1'b0;
			dev_rst_n_ff <= 1'b1;
			cmd_addr_ff <= 3'h0;
			cmd_write_ff <= 1'b0;
			wdata_ff <= 8'h00;
			rdata_ff <= 8'h00;
			mode_ff <= 1'b1;
			mask_ff <= 2'h0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			cs_n_ff <= nxt_cs_n;
			strobe_n_ff <= nxt_strobe_n;
			hoe_ff <= nxt_hoe;
			dev_rst_n_ff <= nxt_dev_rst_n;
			cmd_addr_ff <= nxt_cmd_addr;
			cmd_write_ff <= nxt_cmd_write;
			wdata_ff <= nxt_wdata;
			rdata_ff <= nxt_rdata;
			mode_ff <= nxt_mode;
			mask_ff <= nxt_mask;
		end
	end

	// Strobes gated by direction in both styles
	assign BUS.cs_n = cs_n_ff; // [R3]
	assign BUS.read_strobe_n = strobe_n_ff | cmd_write_ff;
	assign BUS.write_strobe_n = strobe_n_ff | ~cmd_write_ff;
	assign BUS.rw_n = ~cmd_write_ff;
	assign BUS.strobe_mode = mode_ff; // [R4]
	assign BUS.dev_reset_n = dev_rst_n_ff;
	assign BUS.addr = cmd_addr_ff;
	assign BUS.host_data = wdata_ff;
	assign BUS.host_oe = hoe_ff;

endmodule : uart_host_end

/* verification/uart_bus_sva.sv */
`timescale 1ns/1ps
module uart_bus_sva (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic cs_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic rw_n,
	input wire logic strobe_mode,
	input wire logic dev_reset_n,
	input wire logic [2:0] addr,
	input wire logic host_oe,
	input wire logic dev_oe
);
	// ==========================================
	// Cycle decoding
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	wire rd_act = !cs_n && (strobe_mode ? !read_strobe_n : rw_n);
	wire wr_act = !cs_n && (strobe_mode ? !write_strobe_n : !rw_n);
	sequence cyc_start;
		$fell(cs_n);
	endsequence
	sequence cyc_body;
		!cs_n [*3] ##1 cs_n;
	endsequence

	// ==========================================
	// Bus cycle checks
	chk_cycle_len: assert property (cyc_start |-> cyc_body)
		else $error("bus cycle length wrong");
	chk_oe_clash: assert property (!(host_oe && dev_oe))
		else $error("both ends drive data");
	chk_strobe_qual: assert property (
		(!read_strobe_n || !write_strobe_n) |-> !cs_n)
		else $error("strobe without chip select");
	chk_strobe_excl: assert property (
		!(!read_strobe_n && !write_strobe_n))
		else $error("read and write strobes together");
	chk_read_answer: assert property ($rose(rd_act) |=> dev_oe)
		else $error("device late driving read data");
	chk_dev_release: assert property (dev_oe |-> $past(rd_act))
		else $error("device drives outside read");
	chk_addr_hold: assert property (
		!cs_n && $past(!cs_n) |-> $stable(addr))
		else $error("address moved in cycle");
	chk_write_drive: assert property (wr_act |-> host_oe)
		else $error("write without host data");
	chk_reset_pulse: assert property (
		$fell(dev_reset_n) |-> cs_n ##1 dev_reset_n)
		else $error("link reset pulse wrong");
endmodule : uart_bus_sva

/* verification/uart_host_irq_baud_gen_tb.sv */
`timescale 1ns/1ps
module uart_host_irq_baud_gen_tb;
	import uart_host_pkg::*;
	// Arbitrary identification values
	localparam logic [7:0] DEV_ID = 8'hA7;
	localparam logic [7:0] REV_ID = 8'h2E;
	logic CLK = 1'b0;
	logic RESET_N = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA, rd;
	logic PREADY, PSLVERR, IRQ, SAMPLE_TICK, FIFO_ENABLE;
	logic OSC_BUFFERED_OUT, serr, p;
	logic THR_EMPTY = 1'b0;
	logic TX_BELOW_TRIG = 1'b0;
	logic RX_BYTE_HELD = 1'b0;
	logic RX_ABOVE_TRIG = 1'b0;
	logic [1:0] osc_div = 2'h0;
	logic osc_run = 1'b0;
	wire OSC_IN = osc_div[1];
	int n_fail = 0;
	int n_tests = 0;

	uart_bus_if bus();
	uart_host_end u_uart_host_end(.CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE,
		.PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .IRQ, .BUS(bus));
	uart_dev_end #(.DEVICE_CODE(DEV_ID), .REVISION_CODE(REV_ID))
		u_uart_dev_end(.CLK, .RESET_N, .BUS(bus), .OSC_IN, .THR_EMPTY,
		.TX_BELOW_TRIG, .RX_BYTE_HELD, .RX_ABOVE_TRIG, .OSC_BUFFERED_OUT,
		.SAMPLE_TICK, .FIFO_ENABLE);
	uart_bus_sva u_uart_bus_sva(.CLK, .RESET_N, .cs_n(bus.cs_n),
		.read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
		.rw_n(bus.rw_n), .strobe_mode(bus.strobe_mode),
		.dev_reset_n(bus.dev_reset_n), .addr(bus.addr),
		.host_oe(bus.host_oe), .dev_oe(bus.dev_oe));

	// ==========================================
	// Clock and oscillator
	always #50 CLK = ~CLK;
	// Slow oscillator: must stay below half the bus clock
	always @(posedge CLK) if (osc_run) osc_div <= osc_div + 2'h1;

	// ==========================================
	// Access tasks
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		serr = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb

	task automatic idle;
		do apb(1'b0, REG_STATUS, 32'h0); while (rd[STAT_BUSY_BIT] !== 1'b0);
	endtask : idle

	task automatic dev(input logic w, input logic [2:0] a,
		input logic [7:0] d);
		apb(1'b1, REG_WDATA, {24'h0, d});
		apb(1'b1, REG_CMD, {23'h0, w, 5'h0, a});
		idle();
		apb(1'b0, REG_RDATA, 32'h0);
	endtask : dev

	task automatic dchk(input string nm, input logic [2:0] a,
		input logic [7:0] e);
		dev(1'b0, a, 8'h00);
		chk(nm, {24'h0, e}, rd);
	endtask : dchk

	task automatic gap(input int e);
		int n;
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(posedge CLK);
				n++;
			end while (SAMPLE_TICK !== 1'b1 && n < 400);
		end
		chk("tick_gap", e, n);
	endtask : gap

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	// ==========================================
	// Tests
	initial begin
		repeat (40000) @(posedge CLK);
		n_fail++;
		wrap_up();
	end

	initial begin
		repeat (16) @(posedge CLK);
		RESET_N <= 1'b1;
		dchk("div_lo", A_DIV_LO, DIV_LO_RST);
		dchk("div_hi", A_DIV_HI, DIV_HI_RST);
		dchk("unused", 3'h7, 8'h00);
		apb(1'b0, 8'h1C, 32'h0);
		chk("apb_err", 32'h1, serr);
		dev(1'b1, A_DIV_LO, 8'h00);
		dev(1'b1, A_DIV_HI, 8'h00);
		dchk("dev_code", A_DIV_HI, DEV_ID);
		dchk("rev_code", A_DIV_LO, REV_ID);
		apb(1'b1, REG_CTRL, 32'h3);
		idle();
		dchk("rst_lo", A_DIV_LO, DIV_LO_RST);
		// Done event: raised, cleared, then masked
		apb(1'b1, REG_IRQ_STAT, 32'h3);
		apb(1'b1, REG_IRQ_MASK, 32'h1);
		dev(1'b1, A_MODEM_CTRL, 8'h00);
		repeat (2) @(posedge CLK);
		chk("irq_on", 32'h1, IRQ);
		apb(1'b1, REG_IRQ_STAT, 32'h1);
		repeat (2) @(posedge CLK);
		chk("irq_clr", 32'h0, IRQ);
		apb(1'b1, REG_IRQ_MASK, 32'h0);
		dev(1'b1, A_MODEM_CTRL, 8'h00);
		repeat (2) @(posedge CLK);
		chk("irq_mask", 32'h0, IRQ);
		apb(1'b0, REG_IRQ_STAT, 32'h0);
		chk("stat_done", 32'h1, rd[IRQ_DONE_BIT]);
		chk("stat_nodev", 32'h0, rd[IRQ_DEV_BIT]);
		// Bus style, fifo mode, source path and level all varied
		for (int i = 0; i < 16; i++) begin
			apb(1'b1, REG_CTRL, {31'h0, i[2]});
			dev(1'b1, A_FIFO_CTRL, {4'h0, 1'b1, 2'h0, i[1]});
			THR_EMPTY <= !i[3] && (i[0] ^ i[1]);
			TX_BELOW_TRIG <= !i[3] && (i[0] ~^ i[1]);
			RX_BYTE_HELD <= i[3] && (i[0] ^ i[1]);
			RX_ABOVE_TRIG <= i[3] && (i[0] ~^ i[1]);
			dchk("mode_rd", A_DIV_LO, DIV_LO_RST);
			chk("fifo_en", i[1], FIFO_ENABLE);
			chk("irq_pin", i[2] ? i[0] : !i[0], bus.irq_pin);
			dchk("irq_src", A_IRQ_STATE,
				{6'h0, i[3] && i[0], !i[3] && i[0]});
			apb(1'b0, REG_STATUS, 32'h0);
			chk("stat_irq", i[0], rd[STAT_IRQ_BIT]);
		end
		apb(1'b0, REG_IRQ_STAT, 32'h0);
		chk("stat_dev", 32'h1, rd[IRQ_DEV_BIT]);
		apb(1'b1, REG_CTRL, 32'h1);
		// Divisor: osc rate over prescale over 16x rate
		dev(1'b1, A_DIV_LO, 8'h03);
		osc_run <= 1'b1;
		gap(12);
		dev(1'b1, A_MODEM_CTRL, 8'h80);
		gap(48);
		for (int k = 0; k < 8; k++) begin
			@(negedge CLK) p = OSC_IN;
			@(posedge CLK);
			#1 chk("osc_buf", p, OSC_BUFFERED_OUT);
		end
		wrap_up();
	end
endmodule : uart_host_irq_baud_gen_tb
